// ---- host_pins.sv ----
// Purpose: host-side model of the save/restore pins and supply monitor
// Assumes: requests come from the bench right after a rising edge
// Notes: pins are host levels, idle high; save request masks restore
`timescale 1ns/10ps
module host_pins (
    // requests
    input wire logic save_req_i,
    input wire logic restore_req_i,
    input wire logic low_req_i,
    // pins
    output logic save_n_o,
    output logic restore_n_o,
    output logic supply_low_o
);
    assign save_n_o = !save_req_i;
    // both pins low is not a mode, so the host never shows it
    assign restore_n_o = !(restore_req_i && !save_req_i);
    assign supply_low_o = low_req_i;
endmodule

// ---- nvram_ctrl.sv ----
// Purpose: save/restore sequencing for a 16x16 nvram with AHB-Lite access
// Assumes: pins synchronous to clk_i; instructions issued as register writes
// Notes: ctrl at 0x0 (latch set/clear, save, restore, word write), status 0x4, data 0x8
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "nvram_params.svh"
module nvram_ctrl
    import nvram_pkg::*;
#(
    parameter int SAVE_CYCLES = `SAVE_CYCLES,
    parameter int WORDS = 16,
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // save / restore pins, active low
    input wire logic save_n_i,
    input wire logic restore_n_i,
    // supply monitor, high while supply is below the save threshold
    input wire logic supply_low_i,
    // status
    output logic busy_o
);
    localparam int RST_CYCLES = `RESTORE_CYCLES;
    localparam int CW = $clog2(SAVE_CYCLES + 1);

    typedef struct packed {
        op_state_t st;
        logic [CW-1:0] cnt;
        logic latch;
        logic restored;
        bus_phase_t ph;
        logic [31:0] rdata;
    } state_t;

    state_t q, d;
    logic [WIDTH-1:0] ram_q [WORDS];
    logic [WIDTH-1:0] nv_q [WORDS];

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic [31:0] wd;
    logic i_set, i_clr, i_save, i_rest, i_wr;
    logic p_save, p_rest, save_go, rest_go, save_ok;

    assign wd = hwdata_i;
    // an instruction executes in the data phase of a ctrl write
    assign wr_ctrl = q.ph.sel && q.ph.write && q.ph.addr == `ADDR_CTRL;
    assign i_set = wr_ctrl && wd[`CTRL_BIT_SET_LATCH];
    assign i_clr = wr_ctrl && wd[`CTRL_BIT_CLR_LATCH];
    assign i_save = wr_ctrl && wd[`CTRL_BIT_SAVE];
    assign i_rest = wr_ctrl && wd[`CTRL_BIT_RESTORE];
    assign i_wr = wr_ctrl && wd[`CTRL_BIT_DAT_WR];
    // pins count only when no instruction is being executed
    assign p_save = !save_n_i && restore_n_i && !wr_ctrl;
    assign p_rest = !restore_n_i && save_n_i && !wr_ctrl;
    assign save_ok = q.latch && q.restored && !supply_low_i;
    assign save_go = q.st == ST_IDLE && (p_save || i_save) && save_ok;
    // save wins over a coincident restore
    assign rest_go = q.st == ST_IDLE && (p_rest || i_rest) && !save_go;

    // ------------------------------------------------------------
    // operation sequencing
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.ph.sel = hsel_i && hready_i && htrans_i[1];
        d.ph.write = hwrite_i;
        d.ph.addr = haddr_i[3:0];
        if (i_set) begin
            d.latch = 1'b1;
        end
        if (i_clr) begin
            d.latch = 1'b0;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (save_go) begin
                    d.st = ST_SAVE;
                    d.cnt = CW'(SAVE_CYCLES - 1);
                end else if (rest_go) begin
                    d.st = ST_RESTORE;
                    d.cnt = CW'(RST_CYCLES - 1);
                end
            end
            ST_SAVE: begin
                if (q.cnt == '0) begin
                    d.st = ST_IDLE;
                    d.latch = 1'b0;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_RESTORE: begin
                if (q.cnt == '0) begin
                    d.st = ST_IDLE;
                    d.restored = 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            // unused code: drop back to idle rather than lock up
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // read data registered in the address phase, stands through the data phase
        d.rdata = '0;
        if (d.ph.sel && !hwrite_i) begin
            if (haddr_i[3:0] == `ADDR_STATUS) begin
                d.rdata[`ST_BIT_LATCH] = q.latch;
                d.rdata[`ST_BIT_RESTORED] = q.restored;
                d.rdata[`ST_BIT_BUSY_SAVE] = q.st == ST_SAVE;
                d.rdata[`ST_BIT_BUSY_RESTORE] = q.st == ST_RESTORE;
            end else if (haddr_i[3:0] == `ADDR_DATA) begin
                d.rdata[WIDTH-1:0] = ram_q[q.ph.sel && q.ph.write && q.ph.addr == `ADDR_CTRL ?
                    wd[`CTRL_ADDR_LSB +: 4] : hwdata_i[`CTRL_ADDR_LSB +: 4]];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            // power-up restore starts straight after reset
            q.st <= ST_RESTORE;
            q.cnt <= CW'(RST_CYCLES - 1);
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // arrays
    // ------------------------------------------------------------
    // no reset here: the backup copy must outlive a power cycle
    // whole-array copies happen in the final cycle of each operation
    always_ff @(posedge clk_i) begin
        if (q.st == ST_RESTORE && q.cnt == '0) begin
            ram_q <= nv_q;
        end else if (i_wr && q.restored && q.latch && q.st == ST_IDLE) begin
            ram_q[wd[`CTRL_ADDR_LSB +: 4]] <= wd[`CTRL_DATA_LSB +: WIDTH];
        end
        if (q.st == ST_SAVE && q.cnt == '0) begin
            nv_q <= ram_q;
        end
    end

    // ------------------------------------------------------------
    // bus and status outputs
    // ------------------------------------------------------------
    assign hrdata_o = q.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign busy_o = q.st != ST_IDLE;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_save_start;
        q.st == ST_IDLE ##1 q.st == ST_SAVE;
    endsequence
    sequence s_restore_start;
        q.st == ST_IDLE ##1 q.st == ST_RESTORE;
    endsequence
    chk_save_needs_latches: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_save_start |-> $past(q.latch) && $past(q.restored)) else $error("save without latches");
    chk_save_supply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_save_start |-> !$past(supply_low_i)) else $error("save at low supply");
    chk_save_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.st == ST_SAVE && q.cnt == '0 |=> !q.latch) else $error("latch kept after save");
    chk_save_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        save_go |=> q.st == ST_SAVE) else $error("save lost priority");
    chk_restore_any: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.st == ST_IDLE && i_rest && !save_go |=> q.st == ST_RESTORE) else $error("restore refused");
    chk_restore_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_restore_start |-> ##[1:RST_CYCLES] q.st == ST_IDLE) else $error("restore too long");
    chk_restore_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.st == ST_RESTORE && q.cnt == '0 |=> q.restored) else $error("restore latch not set");
    chk_pin_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_ctrl && !i_save && !i_rest && q.st == ST_IDLE |=> q.st == ST_IDLE)
        else $error("pin taken during instruction");
    chk_pin_restore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.st == ST_IDLE && p_rest && !save_go |=> q.st == ST_RESTORE) else $error("pin restore refused");
    chk_save_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_save_start |-> q.cnt == CW'(SAVE_CYCLES - 1)) else $error("save length wrong");
    chk_save_steps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.st == ST_SAVE && q.cnt != '0 |=> q.st == ST_SAVE && q.cnt == $past(q.cnt) - 1'b1)
        else $error("save count skipped");
    chk_latch_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        i_clr |=> !q.latch) else $error("latch not cleared");
    chk_latch_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        i_set && !i_clr && !(q.st == ST_SAVE && q.cnt == '0) |=> q.latch)
        else $error("latch not set");
endmodule

// ---- nvram_params.svh ----
// Purpose: constants for the nvram save/restore controller
// Assumes: 25 MHz system clock (40 ns period)
// Notes: times in their own unit, cycle counts derived from them
`ifndef NVRAM_PARAMS_SVH
`define NVRAM_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define SAVE_TIME_MS 10
`define SAVE_CYCLES ((`SAVE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RESTORE_TIME_NS 1500
`define RESTORE_CYCLES (`RESTORE_TIME_NS / `CLK_PERIOD_NS)
`define ADDR_CTRL 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define ADDR_DATA 32'h0000_0008
`define CTRL_BIT_SET_LATCH 0
`define CTRL_BIT_CLR_LATCH 1
`define CTRL_BIT_SAVE 2
`define CTRL_BIT_RESTORE 3
`define CTRL_BIT_DAT_WR 4
`define CTRL_ADDR_LSB 8
`define CTRL_DATA_LSB 16
`define ST_BIT_LATCH 0
`define ST_BIT_RESTORED 1
`define ST_BIT_BUSY_SAVE 2
`define ST_BIT_BUSY_RESTORE 3
`endif

// ---- nvram_pkg.sv ----
// Purpose: shared types for the nvram save/restore controller
// Assumes: nothing beyond the parameters header
// Notes: state and bus phase carried as packed structs
package nvram_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_RESTORE} op_state_t;
    typedef struct packed {
        logic sel;
        logic write;
        logic [3:0] addr;
    } bus_phase_t;
endpackage

// ---- tb.sv ----
// Purpose: self-checking bench for the save/restore controller
// Assumes: zero-wait slave, save shortened to SC cycles
// Notes: write/save readiness wait is shortened to keep the run short
`timescale 1ns/10ps
module tb;
    import nvram_pkg::*;
    localparam int SC = 50;
    localparam int PUR = 5000;    // 200 us of read readiness after power-up
    localparam int PUW = 25000;   // write/save readiness, cut from 5 ms to fit the run budget
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic hrdy;
    logic hresp;
    logic busy;
    logic sreq = 1'b0;
    logic rreq = 1'b0;
    logic lreq = 1'b0;
    logic save_n;
    logic restore_n;
    logic low;
    int bad_count = 0;
    int n_tests = 0;
    int n;
    always #20 clk_i = !clk_i;
    host_pins i_host (.save_req_i(sreq), .restore_req_i(rreq), .low_req_i(lreq),
        .save_n_o(save_n), .restore_n_o(restore_n), .supply_low_o(low));
    nvram_ctrl #(.SAVE_CYCLES(SC)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .save_n_i(save_n), .restore_n_i(restore_n), .supply_low_i(low), .busy_o(busy));
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    // hwdata also stands in the address phase: data reads take their word address from it
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hwdata <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (hrdy !== 1'b1 && k < 20);
        if (hrdy !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        htrans <= 2'b00;
        hsel <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (hrdy !== 1'b1 && k < 20);
        r = hrdata;
        chk("hresp", 32'h0000_0000, hresp);
        if (hrdy !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // counts busy cycles after waiting a few cycles for busy to rise
    task automatic run_op(input int lim);
        n = 0;
        repeat (4) begin
            if (busy !== 1'b1) begin
                @(negedge clk_i);
            end
        end
        while (busy === 1'b1 && n <= lim) begin
            @(negedge clk_i);
            n++;
        end
        if (n > lim) begin
            bad_count++;
            end_of_test();
        end
    endtask
    task automatic t_powerup();
        @(negedge clk_i);
        run_op(60);
        chk("restore len", 1, (n > 0 && n <= 39));
        repeat (PUR) @(posedge clk_i);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("status", 32'h0000_0002, r & 32'h0000_000f);
        repeat (PUW - PUR) @(posedge clk_i);
    endtask
    task automatic t_refuse();
        ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
        run_op(SC + 5);
        chk("save no latch", 0, n);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        lreq <= 1'b1;
        ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
        run_op(SC + 5);
        chk("save low supply", 0, n);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("latch kept", 32'h0000_0003, r & 32'h0000_000f);
        lreq <= 1'b0;
    endtask
    task automatic t_data();
        ahb(1'b1, 32'h0000_0000, 32'h5a5a_0f10);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
        run_op(SC + 5);
        chk("save len", 1, (n >= SC - 2 && n <= SC + 2));
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("latch cleared", 32'h0000_0002, r & 32'h0000_000f);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        ahb(1'b1, 32'h0000_0000, 32'h1234_0f10);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0f00);
        chk("word written", 32'h0000_1234, r & 32'h0000_ffff);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0008);
        run_op(60);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0f00);
        chk("restored word", 32'h0000_5a5a, r & 32'h0000_ffff);
    endtask
    task automatic t_pins();
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        @(posedge clk_i);
        sreq <= 1'b1;
        rreq <= 1'b1;
        @(posedge clk_i);
        sreq <= 1'b0;
        // restore pin goes low only as the save starts, which must ignore it
        @(posedge clk_i);
        rreq <= 1'b0;
        run_op(SC + 5);
        chk("pin save wins", 1, (n >= SC - 4 && n <= SC + 2));
        ahb(1'b1, 32'h0000_0000, 32'h0000_0003);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("clear wins", 32'h0000_0002, r & 32'h0000_000f);
        @(posedge clk_i);
        rreq <= 1'b1;
        @(posedge clk_i);
        rreq <= 1'b0;
        run_op(60);
        chk("pin restore", 1, (n > 0 && n <= 39));
    endtask
    task automatic t_reset();
        ahb(1'b1, 32'h0000_0000, 32'h7777_0f10);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0f00);
        chk("write without latch", 32'h0000_5a5a, r & 32'h0000_ffff);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        ahb(1'b1, 32'h0000_0000, 32'h1234_0f10);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        run_op(60);
        chk("reset restore len", 1, (n > 0 && n <= 39));
        repeat (PUR) @(posedge clk_i);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("status after reset", 32'h0000_0002, r & 32'h0000_000f);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0f00);
        chk("word after reset", 32'h0000_5a5a, r & 32'h0000_ffff);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_powerup();
        t_refuse();
        t_data();
        t_pins();
        t_reset();
        end_of_test();
    end
endmodule
